// >>> hw/pbsa_consts.svh
// constants for the personality bit store access block
//==========================================================
`ifndef PBSA_CONSTS_SVH
`define PBSA_CONSTS_SVH

//==========================================================
// register map
`define PBSA_ADDR_W 4
`define PBSA_OFS_INDEX 4'h0
`define PBSA_OFS_STATUS 4'h1

//==========================================================
// field positions
`define PBSA_IDX_ROW_LSB 0
`define PBSA_IDX_COL_LSB 3
`define PBSA_ST_ROW0_BIT 0
`define PBSA_ST_PROG_BIT 1
`define PBSA_ST_SENSE_BIT 7

//==========================================================
// reset values
`define PBSA_INDEX_RST 8'h00
`define PBSA_DATA_RST 8'h00

//==========================================================
// timing
`define PBSA_CLK_MHZ 200
`define PBSA_PROG_TIME_US 2
`define PBSA_PROG_CYCLES (`PBSA_PROG_TIME_US * `PBSA_CLK_MHZ)

`endif

// >>> hw/pbsa_pkg.sv
// types for the personality bit store access block
package pbsa_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pbsa_req_t;

  typedef struct packed {
    logic [7:0] index_sel;
    logic program_strobe;
    logic [15:0] prog_cnt;
    logic [7:0] rdata;
  } pbsa_state_t;

endpackage

// >>> hw/pbsa_top.sv
// register access and cell array of the personality bit store
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pbsa_consts.svh"

module pbsa_top
  import pbsa_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `PBSA_PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic vpp_present,
  input wire logic uv_erase,
  output logic vpp_switch_on,
  output logic [2:0] sel_row,
  output logic [2:0] sel_col,
  output logic first_row_flag,
  output logic sensed_bit
);

  //==========================================================
  // reset release
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  //==========================================================
  // index decode helpers
  function automatic logic [2:0] row_of(input logic [7:0] idx);
    row_of = idx[`PBSA_IDX_ROW_LSB +: 3];
  endfunction

  function automatic logic [2:0] col_of(input logic [7:0] idx);
    col_of = idx[`PBSA_IDX_COL_LSB +: 3];
  endfunction

  function automatic logic [5:0] cell_of(input logic [7:0] idx);
    cell_of = {col_of(idx), row_of(idx)};
  endfunction

  function automatic logic idx_wr(input pbsa_req_t r);
    idx_wr = r.wr && (r.addr == `PBSA_OFS_INDEX);
  endfunction

  function automatic logic stat_wr(input pbsa_req_t r);
    stat_wr = r.wr && (r.addr == `PBSA_OFS_STATUS);
  endfunction

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == `PBSA_OFS_INDEX) || (a == `PBSA_OFS_STATUS);
  endfunction

  //==========================================================
  // request bundle
  pbsa_req_t req;

  always_comb begin
    req.addr = reg_addr;
    req.wdata = reg_wdata;
    req.wr = reg_wr;
    req.rd = reg_rd;
  end

  //==========================================================
  // cell array and sense amplifier
  pbsa_state_t st;
  pbsa_state_t next_st;
  logic [63:0] cells;
  logic sense_q;
  logic prog_done;

  always_ff @(posedge ref_clk) begin
    if (uv_erase) begin
      cells <= 64'h0;
    end else if (prog_done) begin
      cells[cell_of(st.index_sel)] <= 1'b1;
    end
    sense_q <= cells[cell_of(st.index_sel)];
  end

  //==========================================================
  // control state
  logic row0;
  logic [7:0] status_val;

  always_comb begin
    row0 = (row_of(st.index_sel) == 3'h0);
    status_val = 8'h00;
    status_val[`PBSA_ST_ROW0_BIT] = row0;
    status_val[`PBSA_ST_PROG_BIT] = st.program_strobe;
    status_val[`PBSA_ST_SENSE_BIT] = sense_q;
  end

  assign prog_done = st.program_strobe && vpp_present &&
                     (32'(st.prog_cnt) == PROG_CYCLES - 1);

  always_comb begin
    next_st = st;
    next_st.rdata = `PBSA_DATA_RST;
    if (req.wr) begin
      case (req.addr)
        `PBSA_OFS_INDEX: begin
          // whole byte stored, upper bits spare
          next_st.index_sel = req.wdata;
        end
        `PBSA_OFS_STATUS: begin
          next_st.program_strobe = req.wdata[`PBSA_ST_PROG_BIT];
        end
        default: begin
          next_st.index_sel = st.index_sel;
        end
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        `PBSA_OFS_INDEX: begin
          next_st.rdata = st.index_sel;
        end
        `PBSA_OFS_STATUS: begin
          next_st.rdata = status_val;
        end
        default: begin
          next_st.rdata = `PBSA_DATA_RST;
        end
      endcase
    end
    // program time counter
    if (!st.program_strobe || !vpp_present || idx_wr(req)) begin
      next_st.prog_cnt = 16'h0;
    end else if (32'(st.prog_cnt) < PROG_CYCLES - 1) begin
      next_st.prog_cnt = st.prog_cnt + 16'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st.index_sel <= `PBSA_INDEX_RST;
      st.program_strobe <= 1'b0;
      st.prog_cnt <= 16'h0;
      st.rdata <= `PBSA_DATA_RST;
    end else begin
      st <= next_st;
    end
  end

  //==========================================================
  // outputs
  assign reg_rdata = st.rdata;
  assign vpp_switch_on = st.program_strobe;
  assign sel_row = row_of(st.index_sel);
  assign sel_col = col_of(st.index_sel);
  assign first_row_flag = row0;
  assign sensed_bit = sense_q;

  //==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_n);

  AST_IDX_WRITE: assert property (
    req.wr && req.addr == `PBSA_OFS_INDEX |=>
      st.index_sel == $past(req.wdata))
    else $error("index write not stored");

  AST_ROW_COL: assert property (
    {sel_col, sel_row} == st.index_sel[5:0])
    else $error("row or column decode wrong");

  AST_SPARE_RB: assert property (
    req.wr && req.addr == `PBSA_OFS_INDEX ##1 req.rd &&
      req.addr == `PBSA_OFS_INDEX && !req.wr |=>
      reg_rdata[7:6] == $past(req.wdata[7:6], 2))
    else $error("spare bits not kept");

  AST_RESET_IDX: assert property (
    $rose(rst_sync_n) |-> st.index_sel == 8'h00 && first_row_flag)
    else $error("index not cleared by reset");

  AST_SENSE: assert property (
    !uv_erase && !prog_done |=>
      sensed_bit == cells[cell_of($past(st.index_sel))])
    else $error("sensed bit not from selected cell");

  AST_PROG: assert property (
    prog_done && !uv_erase && !idx_wr(req) ##1 !uv_erase |=> sensed_bit)
    else $error("programmed cell not read as one");

  AST_ROW_FLAG: assert property (
    first_row_flag == (st.index_sel[2:0] == 3'h0))
    else $error("row zero flag wrong");

  AST_STEP: assert property (
    req.wr && req.addr == `PBSA_OFS_INDEX &&
      req.wdata[5:0] == st.index_sel[5:0] + 6'h1 &&
      st.index_sel[2:0] == 3'h7 |=> first_row_flag &&
      sel_col == $past(sel_col) + 3'h1)
    else $error("column step wrong");

  AST_ERASE: assert property (
    uv_erase ##1 !prog_done |=> !sensed_bit)
    else $error("erased cell not zero");

  AST_RO_BITS: assert property (
    req.rd && req.addr == `PBSA_OFS_STATUS |=>
      reg_rdata[6:2] == 5'h00 &&
      reg_rdata[`PBSA_ST_PROG_BIT] == $past(st.program_strobe))
    else $error("status readback wrong");

  AST_RDATA_ONE: assert property (
    !req.rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");

  AST_IDX_HOLD: assert property (
    !idx_wr(req) |=> $stable(st.index_sel))
    else $error("index changed without a write");

  AST_SEL_PINS: assert property (
    idx_wr(req) |=> cell_of(st.index_sel) == $past(req.wdata[5:0]))
    else $error("selected cell not from written index");

  AST_SPARE_STORE: assert property (
    idx_wr(req) |=> st.index_sel[7:6] == $past(req.wdata[7:6]))
    else $error("spare bits not stored");

  AST_FLAG_SET: assert property (
    idx_wr(req) && req.wdata[2:0] == 3'h0 |=> first_row_flag)
    else $error("row zero flag not set");

  AST_FLAG_CLR: assert property (
    idx_wr(req) && req.wdata[2:0] != 3'h0 |=> !first_row_flag)
    else $error("row zero flag not cleared");

  AST_SENSE_FOLLOW: assert property (
    idx_wr(req) ##1 !uv_erase && !prog_done |=>
      sensed_bit == cells[cell_of($past(req.wdata, 2))])
    else $error("sensed bit not from new cell");

  AST_STROBE_RST: assert property (
    $rose(rst_sync_n) |-> !vpp_switch_on && st.prog_cnt == 16'h0)
    else $error("strobe not cleared by reset");

  AST_STROBE_WR: assert property (
    stat_wr(req) |=> vpp_switch_on == $past(req.wdata[`PBSA_ST_PROG_BIT]))
    else $error("strobe write not stored");

  AST_STROBE_HOLD: assert property (
    !stat_wr(req) |=> $stable(vpp_switch_on))
    else $error("strobe changed without a write");

  AST_CNT_CLEAR: assert property (
    idx_wr(req) || !vpp_present |=> st.prog_cnt == 16'h0)
    else $error("program count not restarted");

  AST_CNT_STEP: assert property (
    st.program_strobe && vpp_present && !idx_wr(req) &&
      32'(st.prog_cnt) < PROG_CYCLES - 1 |=>
      st.prog_cnt == $past(st.prog_cnt) + 16'h1)
    else $error("program count did not advance");

  AST_CELL_SET: assert property (
    prog_done && !uv_erase |=> cells[cell_of($past(st.index_sel))])
    else $error("selected cell not programmed");

  AST_CELL_KEEP: assert property (
    !uv_erase |=> (cells & $past(cells)) == $past(cells))
    else $error("programmed cell lost without erase");

  AST_ONLY_SEL: assert property (
    !uv_erase |=> (cells & ~$past(cells) &
      ~(64'h1 << cell_of($past(st.index_sel)))) == 64'h0)
    else $error("unselected cell programmed");

  AST_ERASE_ALL: assert property (
    uv_erase |=> cells == 64'h0)
    else $error("erase left a cell set");

  AST_IDX_RB: assert property (
    req.rd && req.addr == `PBSA_OFS_INDEX |=> reg_rdata == $past(st.index_sel))
    else $error("index readback wrong");

  AST_STATUS_RB: assert property (
    req.rd && req.addr == `PBSA_OFS_STATUS |=>
      reg_rdata[`PBSA_ST_ROW0_BIT] == $past(first_row_flag) &&
      reg_rdata[`PBSA_ST_SENSE_BIT] == $past(sensed_bit))
    else $error("status flags read back wrong");

  AST_UNMAPPED_RD: assert property (
    req.rd && !mapped(req.addr) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_UNMAPPED_WR: assert property (
    req.wr && !mapped(req.addr) |=>
      $stable(st.index_sel) && $stable(st.program_strobe))
    else $error("unmapped write changed state");

  AST_STAT_WR_IDX: assert property (
    stat_wr(req) |=> $stable(st.index_sel))
    else $error("status write changed index");

  AST_IDX_WR_STROBE: assert property (
    idx_wr(req) |=> $stable(vpp_switch_on))
    else $error("index write changed strobe");

  AST_ROW_STEP: assert property (
    idx_wr(req) && req.wdata[5:0] == st.index_sel[5:0] + 6'h1 &&
      st.index_sel[2:0] != 3'h7 |=> !first_row_flag && $stable(sel_col))
    else $error("row step left its column");

  COV_PROGRAM: cover property (prog_done);
  COV_ROW_WRAP: cover property (
    $past(st.index_sel[2:0]) == 3'h7 && first_row_flag);
  COV_STATUS_RD: cover property (
    req.rd && req.addr == `PBSA_OFS_STATUS);
  COV_ERASE: cover property (uv_erase ##2 !sensed_bit);
  COV_B2B_RB: cover property (
    idx_wr(req) ##1 req.rd && req.addr == `PBSA_OFS_INDEX);

endmodule
`default_nettype wire

// >>> test/pbsa_top_tb_top.sv
// self-checking bench for the personality bit store access block
`timescale 1ns/1ps
`default_nettype none
module pbsa_top_tb_top;
  localparam int PROG = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic vpp_present = 1'b0;
  logic uv_erase = 1'b1;
  logic [7:0] reg_rdata;
  logic vpp_switch_on;
  logic first_row_flag;
  logic sensed_bit;
  logic [2:0] sel_row;
  logic [2:0] sel_col;
  logic [7:0] d;
  int bad_count = 0;
  int num_checks = 0;
  // rows: index, flag, column, row
  logic [14:0] tbl [10] = '{{8'h00, 1'h1, 3'h0, 3'h0}, {8'h01, 1'h0, 3'h0, 3'h1},
    {8'h07, 1'h0, 3'h0, 3'h7}, {8'h08, 1'h1, 3'h1, 3'h0}, {8'h09, 1'h0, 3'h1, 3'h1},
    {8'h37, 1'h0, 3'h6, 3'h7}, {8'h38, 1'h1, 3'h7, 3'h0}, {8'h3f, 1'h0, 3'h7, 3'h7},
    {8'hc0, 1'h1, 3'h0, 3'h0}, {8'ha5, 1'h0, 3'h4, 3'h5}};

  pbsa_top #(.PROG_CYCLES(PROG)) dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .vpp_present(vpp_present),
    .uv_erase(uv_erase),
    .vpp_switch_on(vpp_switch_on),
    .sel_row(sel_row),
    .sel_col(sel_col),
    .first_row_flag(first_row_flag),
    .sensed_bit(sensed_bit)
  );

  always #2.5 ref_clk = ~ref_clk;

  //==========================================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic sel(input logic [7:0] v);
    wr(4'h0, v);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  //==========================================================
  // tests
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    uv_erase <= 1'b0;
    rd(4'h0);
    chk(d, 8'h00);
    rd(4'h1);
    chk(d, 8'h01);
    $display("test reset done");
    foreach (tbl[i]) begin
      sel(tbl[i][14:7]);
      chk({1'h0, first_row_flag, sel_col, sel_row}, {1'h0, tbl[i][6:0]});
      chk({7'h00, sensed_bit}, 8'h00);
      rd(4'h0);
      chk(d, tbl[i][14:7]);
      rd(4'h1);
      chk(d, {7'h00, tbl[i][6]});
    end
    $display("test table done");
    for (int i = 1; i <= 8; i++) begin
      sel(8'(i));
      chk({7'h00, first_row_flag}, (i == 8) ? 8'h01 : 8'h00);
    end
    wr(4'h5, 8'hff);
    rd(4'h5);
    chk(d, 8'h00);
    rd(4'h0);
    chk(d, 8'h08);
    @(posedge ref_clk);
    #1 chk(reg_rdata, 8'h00);
    @(posedge ref_clk);
    reg_addr <= 4'h0;
    reg_wdata <= 8'hc5;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d, 8'hc5);
    $display("test walk and unmapped done");
    @(posedge ref_clk);
    vpp_present <= 1'b1;
    sel(8'h0a);
    wr(4'h1, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, vpp_switch_on}, 8'h01);
    repeat (10) @(posedge ref_clk);
    rd(4'h1);
    chk(d, 8'h82);
    chk({7'h00, sensed_bit}, 8'h01);
    wr(4'h1, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, vpp_switch_on}, 8'h00);
    rd(4'h1);
    chk(d, 8'h80);
    sel(8'h0b);
    rd(4'h1);
    chk(d, 8'h00);
    wr(4'h1, 8'hfd);
    rd(4'h1);
    chk(d, 8'h00);
    @(posedge ref_clk);
    vpp_present <= 1'b0;
    sel(8'h0c);
    wr(4'h1, 8'h02);
    repeat (12) @(posedge ref_clk);
    wr(4'h1, 8'h00);
    rd(4'h1);
    chk(d, 8'h00);
    $display("test program done");
    sel(8'h0a);
    wr(4'h1, 8'h02);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h00, vpp_switch_on}, 8'h00);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(4'h0);
    chk(d, 8'h00);
    sel(8'h0a);
    chk({7'h00, sensed_bit}, 8'h01);
    rd(4'h1);
    chk(d, 8'h80);
    $display("test mid reset done");
    end_of_test();
  end

  initial begin
    repeat (4000) @(posedge ref_clk);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
